// ---- rtl/icu_pkg.sv ----
// Shared constants, register map and types of the input conditioning unit
package icu_pkg;
    // --------------------------------------------------------------
    // Clock and timing
    // --------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int FILTER_TICK_NS = 1_000_000;
    localparam int FILTER_TICK_CYCLES = (FILTER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] FILTER_DEFAULT_MS = 4'h3;
    localparam logic [3:0] FILTER_FIXED_MS = 4'h3;
    localparam logic [3:0] FILTER_MIN_MS = 4'h3;
    localparam logic [3:0] FILTER_PHASE_MS = 4'h1;
    localparam int FREQ_MIN_HZ = 200;
    localparam int FREQ_MAX_HZ = 10_000;
    localparam int ANALOG_FULL_SCALE = 1000;
    localparam logic [10:0] ANALOG_SCALE_MUL = 11'h3E9;
    // --------------------------------------------------------------
    // Line layout
    // --------------------------------------------------------------
    localparam int GROUPED_LINES = 8;
    localparam int FREQ_FIRST_LINE = 2;
    localparam int FREQ_GROUPS = 4;
    localparam int ANALOG_FIRST_LINE = 6;
    localparam int DIV_UNITS = 6;
    localparam int DIV_NUM_W = 25;
    localparam int DIV_DEN_W = 18;
    // --------------------------------------------------------------
    // Register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FUNC_OFS = 8'h04;
    localparam logic [7:0] FILTER_OFS = 8'h08;
    localparam logic [7:0] AFILT_OFS = 8'h0C;
    localparam logic [7:0] IN_IMAGE_OFS = 8'h10;
    localparam logic [7:0] IN_NOW_OFS = 8'h14;
    localparam logic [7:0] OUT_IMAGE_OFS = 8'h18;
    localparam logic [7:0] OUT_NOW_OFS = 8'h1C;
    localparam logic [7:0] FREQ_BASE_OFS = 8'h20;
    localparam logic [7:0] ANALOG_BASE_OFS = 8'h40;
    localparam int CTRL_LOADED_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [15:0] FUNC_RESET = 16'h0000;
    localparam logic [15:0] FILTER_RESET = 16'h3333;
    localparam logic [15:0] AFILT_RESET = 16'h0000;
    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        FUNC_NORMAL = 2'b00,
        FUNC_FREQ = 2'b01,
        FUNC_FAST = 2'b10,
        FUNC_ANALOG = 2'b11
    } line_func_t;
    typedef enum logic [1:0] {
        A_IDLE = 2'b00,
        A_READ = 2'b01,
        A_UPD = 2'b10
    } avg_state_t;
endpackage : icu_pkg

// ---- rtl/avg_history_mem.sv ----
// Sample history memory for the analog moving average
`timescale 1ns/10ps
module avg_history_mem #(
    parameter int AW = 9,
    parameter int DW = 10
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Stale contents are never read: the window fill count gates them
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : avg_history_mem

// ---- rtl/input_conditioning_unit.sv ----
// Input filter, frequency measurement and analog averaging with APB registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
// How it works
// - Pulse periods are counted in hardware, independent of the scan.
// - Each frequency result is 32 bits, read as high and low words.
// - Integer division truncates; cycle resolution keeps error under one percent.
// - Frequency result registers are refreshed on every scan tick.
// - Slow pulses update the result at the first scan after the period ends.
// - Frequency measurement may be set on lines 2 to 5, each its own line.
// - Frequency function written to lines 6 or 7 is refused with an error.
// - Measuring runs only with configuration loaded and run state set.
// - Four group filter fields accept 0 or 3 to 15 ms.
// - All four group filter fields reset to 3 ms.
// - Lines from index 8 up use a fixed 3 ms filter.
// - Pulses under value minus 2 ms are dropped; value or longer pass.
// - Non-normal line functions bypass the filter.
// - Analog-capable lines set as digital keep the normal filter.
// - Analog samples are scaled to codes 0 to 1000.
// - Each analog result register is refreshed once per scan.
// - Count 0 passes samples; count n averages the last n scans.
// - Raw inputs and an output register are reachable at once, outside scans.
module input_conditioning_unit #(
    parameter int N_IN = 16,
    parameter int N_OUT = 16,
    parameter int FILTER_TICK_CYCLES = icu_pkg::FILTER_TICK_CYCLES,
    parameter int ANALOG_RAW_W = 10
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SCAN_TICK,
    input wire logic [N_IN-1:0] IN_LINE,
    input wire logic [ANALOG_RAW_W-1:0] ANALOG_RAW0,
    input wire logic [ANALOG_RAW_W-1:0] ANALOG_RAW1,
    output logic [N_OUT-1:0] OUT_LINE
);
    localparam int NW = icu_pkg::DIV_NUM_W;
    localparam int PW = icu_pkg::DIV_DEN_W;

    if (N_IN < icu_pkg::GROUPED_LINES || N_IN > 32 || N_OUT < 1 || N_OUT > 32) begin : g_chk_w
        $error("Line counts must be 8..32 inputs and 1..32 outputs");
    end
    if (FILTER_TICK_CYCLES < 2 || FILTER_TICK_CYCLES > 65535) begin : g_chk_t
        $error("Filter tick must be 2..65535 cycles");
    end
    if (ANALOG_RAW_W < 8 || ANALOG_RAW_W > 16) begin : g_chk_a
        $error("Analog sample width must be 8..16");
    end

    // --------------------------------------------------------------
    // Registers and bus
    // --------------------------------------------------------------
    logic [1:0] ctrl;
    logic [15:0] func;
    logic [15:0] filter;
    logic [15:0] afilt;
    logic [N_IN-1:0] in_image;
    logic [N_OUT-1:0] out_image;
    logic [31:0] freq_res [icu_pkg::FREQ_GROUPS];
    logic [15:0] ana_res [2];
    wire [N_IN-1:0] filt_state;
    wire [NW-1:0] d_res [icu_pkg::DIV_UNITS];
    wire d_start [icu_pkg::DIV_UNITS];
    wire [NW-1:0] d_num [icu_pkg::DIV_UNITS];
    wire [PW-1:0] d_den [icu_pkg::DIV_UNITS];

    wire access = PSEL && PENABLE && !PREADY;
    wire fire = PSEL && PENABLE && PREADY;
    wire is_freq = PADDR[7:5] == icu_pkg::FREQ_BASE_OFS[7:5] && PADDR[1:0] == 2'h0;
    wire is_ana = PADDR[7:3] == icu_pkg::ANALOG_BASE_OFS[7:3] && PADDR[1:0] == 2'h0;
    wire [31:0] freq_word = freq_res[PADDR[4:3]];
    wire [31:0] freq_half = PADDR[2] ? {16'h0000, freq_word[15:0]}
                                     : {16'h0000, freq_word[31:16]};
    wire [31:0] rd_mux =
        (PADDR == icu_pkg::CTRL_OFS) ? {30'h0, ctrl} :
        (PADDR == icu_pkg::FUNC_OFS) ? {16'h0000, func} :
        (PADDR == icu_pkg::FILTER_OFS) ? {16'h0000, filter} :
        (PADDR == icu_pkg::AFILT_OFS) ? {16'h0000, afilt} :
        (PADDR == icu_pkg::IN_IMAGE_OFS) ? 32'(in_image) :
        (PADDR == icu_pkg::IN_NOW_OFS) ? 32'(IN_LINE) :
        (PADDR == icu_pkg::OUT_IMAGE_OFS) ? 32'(out_image) :
        (PADDR == icu_pkg::OUT_NOW_OFS) ? 32'(OUT_LINE) :
        is_freq ? freq_half :
        is_ana ? {16'h0000, ana_res[PADDR[2]]} : 32'h0000_0000;
    wire writable = PADDR == icu_pkg::CTRL_OFS || PADDR == icu_pkg::FUNC_OFS ||
                    PADDR == icu_pkg::FILTER_OFS || PADDR == icu_pkg::AFILT_OFS ||
                    PADDR == icu_pkg::OUT_IMAGE_OFS || PADDR == icu_pkg::OUT_NOW_OFS;
    wire readable = writable || PADDR == icu_pkg::IN_IMAGE_OFS ||
                    PADDR == icu_pkg::IN_NOW_OFS || is_freq || is_ana;

    // Function legality: frequency only on lines 2..5, analog only on 6 and 7
    logic [7:0] func_bad;
    logic [3:0] filt_bad;
    for (genvar i = 0; i < icu_pkg::GROUPED_LINES; i++) begin : g_fchk
        wire [1:0] f = PWDATA[2*i +: 2];
        wire freq_ok = i >= icu_pkg::FREQ_FIRST_LINE &&
                       i < icu_pkg::FREQ_FIRST_LINE + icu_pkg::FREQ_GROUPS;
        wire ana_ok = i >= icu_pkg::ANALOG_FIRST_LINE;
        assign func_bad[i] = (f == icu_pkg::FUNC_FREQ && !freq_ok) ||
                             (f == icu_pkg::FUNC_ANALOG && !ana_ok);
    end
    for (genvar g = 0; g < 4; g++) begin : g_vchk
        wire [3:0] v = PWDATA[4*g +: 4];
        assign filt_bad[g] = v != 4'h0 && v < icu_pkg::FILTER_MIN_MS;
    end
    wire bad_value = (PADDR == icu_pkg::FUNC_OFS && func_bad != 8'h00) ||
                     (PADDR == icu_pkg::FILTER_OFS && filt_bad != 4'h0);
    wire next_err = PWRITE ? (!writable || bad_value) : !readable;
    wire wr_ok = fire && PWRITE && !PSLVERR;

    // One wait state: the answer is registered while the request is held
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= access;
            PRDATA <= (access && !PWRITE) ? rd_mux : 32'h0000_0000;
            PSLVERR <= access && next_err;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl <= icu_pkg::CTRL_RESET;
            func <= icu_pkg::FUNC_RESET;
            filter <= icu_pkg::FILTER_RESET;
            afilt <= icu_pkg::AFILT_RESET;
            out_image <= '0;
        end else if (wr_ok) begin
            if (PADDR == icu_pkg::CTRL_OFS) ctrl <= PWDATA[1:0];
            if (PADDR == icu_pkg::FUNC_OFS) func <= PWDATA[15:0];
            if (PADDR == icu_pkg::FILTER_OFS) filter <= PWDATA[15:0];
            if (PADDR == icu_pkg::AFILT_OFS) afilt <= PWDATA[15:0];
            if (PADDR == icu_pkg::OUT_IMAGE_OFS) out_image <= PWDATA[N_OUT-1:0];
        end
    end

    // Immediate output write beats the scan copy of the image
    wire out_now_wr = wr_ok && PADDR == icu_pkg::OUT_NOW_OFS;
    wire [N_OUT-1:0] next_out = out_now_wr ? PWDATA[N_OUT-1:0] :
                                SCAN_TICK ? out_image : OUT_LINE;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            OUT_LINE <= '0;
        end else begin
            OUT_LINE <= next_out;
        end
    end

    // --------------------------------------------------------------
    // Digital input filter
    // --------------------------------------------------------------
    logic [15:0] tick_cnt;
    wire ms_tick = tick_cnt == 16'(FILTER_TICK_CYCLES - 1);
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= ms_tick ? 16'h0000 : tick_cnt + 16'h0001;
        end
    end

    // The tick phase is free-running, so a pulse sees one tick less than
    // its length at worst; the threshold sits one tick below the value.
    for (genvar i = 0; i < N_IN; i++) begin : g_filt
        wire [1:0] lf;
        wire [3:0] val;
        if (i < icu_pkg::GROUPED_LINES) begin : g_grp
            assign lf = func[2*i +: 2];
            assign val = filter[4*(i/2) +: 4];
        end else begin : g_fix
            assign lf = icu_pkg::FUNC_NORMAL;
            assign val = icu_pkg::FILTER_FIXED_MS;
        end
        wire bypass = lf != icu_pkg::FUNC_NORMAL || val == 4'h0;
        wire [3:0] thr = val - icu_pkg::FILTER_PHASE_MS;
        logic state;
        logic [3:0] cnt;
        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                state <= 1'b0;
                cnt <= 4'h0;
            end else if (bypass || IN_LINE[i] == state) begin
                state <= IN_LINE[i];
                cnt <= 4'h0;
            end else if (ms_tick) begin
                cnt <= (cnt + 4'h1 == thr) ? 4'h0 : cnt + 4'h1;
                state <= (cnt + 4'h1 == thr) ? IN_LINE[i] : state;
            end
        end
        assign filt_state[i] = state;
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            in_image <= '0;
        end else if (SCAN_TICK) begin
            in_image <= filt_state;
        end
    end

    // --------------------------------------------------------------
    // Serial dividers: four for frequency, two for the averages
    // --------------------------------------------------------------
    for (genvar d = 0; d < icu_pkg::DIV_UNITS; d++) begin : g_div
        logic [NW-1:0] q;
        logic [PW-1:0] r;
        logic [PW-1:0] den;
        logic [4:0] k;
        logic busy;
        logic [NW-1:0] res;
        wire [PW:0] trial = {r, q[NW-1]};
        wire fit = trial >= {1'b0, den};
        wire [PW-1:0] next_r = fit ? PW'(trial - {1'b0, den}) : trial[PW-1:0];
        wire [NW-1:0] next_q = {q[NW-2:0], fit};
        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                q <= '0;
                r <= '0;
                den <= '0;
                k <= 5'h00;
                busy <= 1'b0;
                res <= '0;
            end else if (d_start[d]) begin
                q <= d_num[d];
                r <= '0;
                den <= d_den[d];
                k <= 5'(NW);
                busy <= 1'b1;
            end else if (busy) begin
                q <= next_q;
                r <= next_r;
                k <= k - 5'h01;
                busy <= k != 5'h01;
                res <= (k == 5'h01) ? next_q : res;
            end
        end
        assign d_res[d] = res;
    end

    // --------------------------------------------------------------
    // Frequency measurement
    // --------------------------------------------------------------
    wire running = ctrl[icu_pkg::CTRL_LOADED_BIT] && ctrl[icu_pkg::CTRL_RUN_BIT];
    wire [3:0] fm_en;
    for (genvar g = 0; g < icu_pkg::FREQ_GROUPS; g++) begin : g_freq
        localparam int LN = g + icu_pkg::FREQ_FIRST_LINE;
        assign fm_en[g] = running && func[2*LN +: 2] == icu_pkg::FUNC_FREQ;
        logic prev;
        logic armed;
        logic have;
        logic [PW-1:0] pcnt;
        wire rise = IN_LINE[LN] && !prev;
        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                prev <= 1'b0;
                armed <= 1'b0;
                have <= 1'b0;
                pcnt <= '0;
            end else begin
                prev <= IN_LINE[LN];
                armed <= fm_en[g] && (armed || rise);
                have <= fm_en[g] && (have || d_start[g]);
                pcnt <= (!fm_en[g] || rise) ? PW'(1) : (&pcnt ? pcnt : pcnt + PW'(1));
            end
        end
        assign d_start[g] = fm_en[g] && armed && rise;
        assign d_num[g] = NW'(icu_pkg::CLK_HZ);
        assign d_den[g] = pcnt;
        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                freq_res[g] <= 32'h0000_0000;
            end else if (SCAN_TICK) begin
                freq_res[g] <= have ? 32'(d_res[g]) : 32'h0000_0000;
            end
        end
    end

    // --------------------------------------------------------------
    // Analog conversion and moving average
    // --------------------------------------------------------------
    icu_pkg::avg_state_t a_state;
    logic ach;
    logic [7:0] wptr;
    logic [9:0] code [2];
    logic [17:0] sum [2];
    logic [7:0] filled [2];
    logic [7:0] nlast [2];
    wire [9:0] old_sample;
    wire [ANALOG_RAW_W+10:0] prod0 = ANALOG_RAW0 * icu_pkg::ANALOG_SCALE_MUL;
    wire [ANALOG_RAW_W+10:0] prod1 = ANALOG_RAW1 * icu_pkg::ANALOG_SCALE_MUL;
    wire [9:0] conv0 = prod0[ANALOG_RAW_W +: 10];
    wire [9:0] conv1 = prod1[ANALOG_RAW_W +: 10];
    wire [7:0] n_cur = afilt[8*ach +: 8];
    wire restart = n_cur != nlast[ach];
    wire full = filled[ach] == n_cur;
    wire [17:0] next_sum = restart ? 18'(code[ach]) :
        18'(sum[ach] + 18'(code[ach]) - (full ? 18'(old_sample) : 18'h00000));
    wire [7:0] next_filled = restart ? 8'h01 : (full ? filled[ach] : filled[ach] + 8'h01);
    wire upd = a_state == icu_pkg::A_UPD;

    avg_history_mem #(.AW(9), .DW(10)) u_hist (
        .clock(CLOCK),
        .rst_b(RST_B),
        .we(upd),
        .waddr({ach, wptr}),
        .wdata(code[ach]),
        .raddr({ach, 8'(wptr - n_cur)}),
        .rdata(old_sample)
    );

    for (genvar c = 0; c < 2; c++) begin : g_ana
        wire mine = upd && ach == 1'(c);
        assign d_start[4+c] = mine && n_cur != 8'h00;
        assign d_num[4+c] = NW'(next_sum);
        assign d_den[4+c] = PW'(next_filled);
        always_ff @(posedge CLOCK or negedge RST_B) begin
            if (!RST_B) begin
                sum[c] <= 18'h00000;
                filled[c] <= 8'h00;
                nlast[c] <= 8'h00;
                ana_res[c] <= 16'h0000;
            end else begin
                sum[c] <= mine ? next_sum : sum[c];
                filled[c] <= mine ? next_filled : filled[c];
                nlast[c] <= mine ? n_cur : nlast[c];
                if (SCAN_TICK) begin
                    ana_res[c] <= (afilt[8*c +: 8] == 8'h00) ? 16'(code[c])
                                                            : 16'(d_res[4+c]);
                end
            end
        end
    end

    // Results lag the sample by one scan; the divide must finish in between
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            a_state <= icu_pkg::A_IDLE;
            ach <= 1'b0;
            wptr <= 8'h00;
            code[0] <= 10'h000;
            code[1] <= 10'h000;
        end else begin
            unique case (a_state)
                icu_pkg::A_IDLE: begin
                    if (SCAN_TICK) begin
                        code[0] <= conv0;
                        code[1] <= conv1;
                        ach <= 1'b0;
                        a_state <= icu_pkg::A_READ;
                    end
                end
                icu_pkg::A_READ: begin
                    a_state <= icu_pkg::A_UPD;
                end
                icu_pkg::A_UPD: begin
                    ach <= 1'b1;
                    wptr <= ach ? wptr + 8'h01 : wptr;
                    a_state <= ach ? icu_pkg::A_IDLE : icu_pkg::A_READ;
                end
                default: begin
                    a_state <= icu_pkg::A_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    a_apb_wait_one: assert property (s_access |=> PREADY ##1 !PREADY)
        else $error("Slave did not answer after one wait state");
    a_func_reject: assert property ((s_access and (PWRITE && PADDR == icu_pkg::FUNC_OFS &&
        PWDATA[13:12] == icu_pkg::FUNC_FREQ)) |=> PSLVERR ##1 $stable(func))
        else $error("Frequency function on line 6 was accepted");
    a_filter_legal: assert property (filter[3:0] == 4'h0 || filter[3:0] >= 4'h3)
        else $error("Illegal filter value stored");
    a_freq_gate: assert property (!running |-> !d_start[0] && !d_start[1])
        else $error("Frequency measurement started while not running");
    a_freq_on_scan: assert property ($changed(freq_res[1]) |-> $past(SCAN_TICK))
        else $error("Frequency result changed outside a scan tick");
    a_ana_on_scan: assert property ($changed(ana_res[0]) |-> $past(SCAN_TICK))
        else $error("Analog result changed outside a scan tick");
    a_ana_range: assert property (code[0] <= 10'd1000 && code[1] <= 10'd1000)
        else $error("Analog code above full scale");
    a_bypass_fast: assert property (func[5:4] == icu_pkg::FUNC_FAST |=>
        filt_state[2] == $past(IN_LINE[2]))
        else $error("Filter not bypassed on a fast line");
    a_fixed_hold: assert property ($changed(filt_state[8]) |->
        $past(IN_LINE[8]) != $past(filt_state[8], 2) || $past(ms_tick))
        else $error("Fixed filter line changed without a tick");
    a_div_length: assert property ($rose(g_div[4].busy) |-> g_div[4].busy[*8])
        else $error("Average divider ended too early");
endmodule : input_conditioning_unit

// ---- verification/field_source.sv ----
// Field signal source model driving the discrete input lines
`timescale 1ns/10ps
module field_source #(
    parameter int PERIOD = 2500
) (
    input wire logic clock,
    input wire logic pulse_on,
    input wire logic [15:0] level,
    output logic [15:0] in_line
);
    // ------------------------------------------------
    // Square wave on line 2, steady levels elsewhere
    // ------------------------------------------------
    int cnt = 0;
    always @(posedge clock) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
    // Half-period pulses stay far longer than any filter value plus a scan
    assign in_line = level | {13'h0000, pulse_on && (cnt < PERIOD / 2), 2'h0};
endmodule : field_source

// ---- verification/tb_top.sv ----
// Self-checking bench for the input conditioning unit
`timescale 1ns/10ps
module tb_top;
    // ------------------------------------------------
    // Clock, scan, instances and bus tasks
    // ------------------------------------------------
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic SCAN_TICK = 1'b0;
    logic pulse_on = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic [15:0] level = 16'h0000;
    logic [15:0] IN_LINE;
    logic [15:0] OUT_LINE;
    logic [9:0] raw0 = 10'h200;
    logic [9:0] raw1 = 10'h3FF;
    int n_fail = 0;
    int total_checks = 0;
    int tick_cnt = 0;
    always #20 CLOCK = ~CLOCK;
    // Scan spacing of 200 cycles leaves the averager ample time
    always @(posedge CLOCK) begin
        tick_cnt <= (tick_cnt == 199) ? 0 : tick_cnt + 1;
        SCAN_TICK <= (tick_cnt == 199);
    end
    field_source #(.PERIOD(2500)) u_field_source (.clock(CLOCK), .pulse_on(pulse_on),
        .level(level), .in_line(IN_LINE));
    input_conditioning_unit #(.FILTER_TICK_CYCLES(10)) u_input_conditioning_unit (
        .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SCAN_TICK(SCAN_TICK), .IN_LINE(IN_LINE),
        .ANALOG_RAW0(raw0), .ANALOG_RAW1(raw1), .OUT_LINE(OUT_LINE));
    task close_out;
        $display("Checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err,
        input logic [31:0] exp, input logic [31:0] mask);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        @(posedge CLOCK);
        while (PREADY !== 1'b1) @(posedge CLOCK);
        chk("pslverr", {31'h0, err}, {31'h0, PSLVERR});
        if (!wr) chk("prdata", exp, PRDATA & mask);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task tick;
        @(posedge CLOCK iff SCAN_TICK);
    endtask : tick
    initial begin
        #2_000_000;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge CLOCK);
        RST_B <= 1'b1;
        apb(1'b0, 8'h08, 32'h0, 1'b0, 32'h3333, 32'hFFFF);
        apb(1'b1, 8'h08, 32'h3332, 1'b1, 32'h0, 32'h0);
        apb(1'b1, 8'h08, 32'h30F0, 1'b0, 32'h0, 32'h0);
        apb(1'b0, 8'h08, 32'h0, 1'b0, 32'h30F0, 32'hFFFF);
        apb(1'b1, 8'h04, 32'h1000, 1'b1, 32'h0, 32'h0);
        apb(1'b1, 8'h20, 32'h1, 1'b1, 32'h0, 32'h0);
        apb(1'b0, 8'h80, 32'h0, 1'b1, 32'h0, 32'h0);
        level <= 16'h0140;
        repeat (5) @(posedge CLOCK);
        level <= 16'h0000;
        repeat (400) @(posedge CLOCK);
        apb(1'b0, 8'h10, 32'h0, 1'b0, 32'h0, 32'h140);
        level <= 16'h0140;
        repeat (500) @(posedge CLOCK);
        apb(1'b0, 8'h10, 32'h0, 1'b0, 32'h140, 32'h140);
        apb(1'b0, 8'h14, 32'h0, 1'b0, 32'h140, 32'h140);
        apb(1'b1, 8'h18, 32'h5A, 1'b0, 32'h0, 32'h0);
        tick();
        apb(1'b1, 8'h1C, 32'hA5, 1'b0, 32'h0, 32'h0);
        @(negedge CLOCK);
        chk("out_line", 32'hA5, {16'h0000, OUT_LINE});
        apb(1'b0, 8'h1C, 32'h0, 1'b0, 32'hA5, 32'hFFFF);
        tick();
        @(negedge CLOCK);
        chk("out_line", 32'h5A, {16'h0000, OUT_LINE});
        apb(1'b1, 8'h04, 32'h10, 1'b0, 32'h0, 32'h0);
        pulse_on <= 1'b1;
        repeat (8000) @(posedge CLOCK);
        apb(1'b0, 8'h24, 32'h0, 1'b0, 32'h0, 32'hFFFFFFFF);
        apb(1'b1, 8'h00, 32'h3, 1'b0, 32'h0, 32'h0);
        repeat (10000) @(posedge CLOCK);
        apb(1'b0, 8'h20, 32'h0, 1'b0, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, 8'h24, 32'h0, 1'b0, 32'h2710, 32'hFFFFFFFF);
        apb(1'b0, 8'h40, 32'h0, 1'b0, 32'h1F4, 32'hFFFF);
        apb(1'b0, 8'h44, 32'h0, 1'b0, 32'h3E8, 32'hFFFF);
        apb(1'b1, 8'h0C, 32'h2, 1'b0, 32'h0, 32'h0);
        repeat (4) tick();
        tick();
        raw0 <= 10'h000;
        tick();
        tick();
        apb(1'b0, 8'h40, 32'h0, 1'b0, 32'hFA, 32'hFFFF);
        apb(1'b1, 8'h04, 32'h20, 1'b0, 32'h0, 32'h0);
        tick();
        tick();
        apb(1'b0, 8'h24, 32'h0, 1'b0, 32'h0, 32'hFFFFFFFF);
        close_out();
    end
endmodule : tb_top
